// >>> rtl/ctfs_map.vh
// constants for the can transceiver fault supervisor
`ifndef CTFS_MAP_VH
`define CTFS_MAP_VH
`define CTFS_CLK_MHZ            100
`define CTFS_FAULT_EDGES        4
`define CTFS_DOM_MIN_NS         1500
`define CTFS_DOM_MIN_CYC        ((`CTFS_DOM_MIN_NS * `CTFS_CLK_MHZ + 999) / 1000)
`define CTFS_RECHECK_MS         300
`define CTFS_RECHECK_CYC        (`CTFS_RECHECK_MS * 1000 * `CTFS_CLK_MHZ)
`define CTFS_DTO_US             1000
`define CTFS_DTO_CYC            (`CTFS_DTO_US * `CTFS_CLK_MHZ)
`define CTFS_BUV_FLT_US         100
`define CTFS_BUV_FLT_CYC        (`CTFS_BUV_FLT_US * `CTFS_CLK_MHZ)
`define CTFS_RUV_FLT_US         100
`define CTFS_RUV_FLT_CYC        (`CTFS_RUV_FLT_US * `CTFS_CLK_MHZ)
`define CTFS_UVSLP_MS           200
`define CTFS_UVSLP_CYC          (`CTFS_UVSLP_MS * 1000 * `CTFS_CLK_MHZ)
`define CTFS_BF_HCANL           0
`define CTFS_BF_HBAT            1
`define CTFS_BF_LGND            2
`define CTFS_BF_OPEN            3
`define CTFS_BF_BUSGND          4
`define CTFS_BF_BUSBAT          5
`define CTFS_BF_W               6
`define CTFS_MODE_SLEEP         2'h0
`define CTFS_MODE_STANDBY       2'h1
`define CTFS_MODE_NORMAL        2'h2
`define CTFS_MODE_FAILSAFE      2'h3
`define CTFS_ST_STANDBY         3'h0
`define CTFS_ST_NORMAL          3'h1
`define CTFS_ST_SLEEP           3'h2
`define CTFS_ST_TSD             3'h3
`define CTFS_ST_FAILSAFE        3'h4
`define CTFS_ST_BUV             3'h5
`endif

// >>> rtl/ctfs_filter.v
// persistence filter: output rises after input held high for the given count
`timescale 1ns/10ps
`default_nettype none
module ctfs_filter #(
    parameter CNT = 10
) (
    input  wire clk_sys_i,  // system clock
    input  wire rst_i,      // async reset
    input  wire level_i,    // raw condition
    output reg  hit_o       // condition confirmed
);
    reg [31:0] cnt_r;
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 32'h0;
            hit_o <= 1'b0;
        end else if (!level_i) begin
            cnt_r <= 32'h0;
            hit_o <= 1'b0;
        end else if (cnt_r >= CNT - 1) begin
            hit_o <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h1;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/ctfs_supervisor.v
// fault supervision and protection state logic of a can transceiver
// Notes on behaviour
// - bus fault needs four long-dominant transitions
// - classify six bus fault kinds with flags
// - thermal warning raises interrupt
// - thermal shutdown disables transceiver, blocks transmit
// - thermal shutdown sets flag and interrupt
// - register port stays alive during shutdown
// - recheck overtemperature every 300 ms
// - thermal shutdown ignores normal/standby, accepts sleep
// - fail-safe enabled: shutdown enters fail-safe
// - long low on transmit disables driver
// - transmit high re-enables driver, clears timeout
// - timeout keeps receiver active, bus recessive
// - undervoltage enters protected bus-safe state
// - battery undervoltage blocks host signalling
// - battery undervoltage filtered before declared
// - battery undervoltage turns off inhibit output
// - battery recovery enters standby, starts error timer
// - regulator undervoltage filtered before sleep timer
// - sleep timer expiry with undervoltage enters sleep
// - regulator overvoltage sets flag, enters fail-safe
// - fail-safe keeps transceiver disabled
// - high is recessive, low is dominant
// - fault flags reset zero, write-one clears
`timescale 1ns/10ps
`default_nettype none
`include "ctfs_map.vh"
module ctfs_supervisor #(
    parameter RECHECK_CYC = `CTFS_RECHECK_CYC,
    parameter DTO_CYC     = `CTFS_DTO_CYC,
    parameter BUV_CYC     = `CTFS_BUV_FLT_CYC,
    parameter RUV_CYC     = `CTFS_RUV_FLT_CYC,
    parameter UVSLP_CYC   = `CTFS_UVSLP_CYC,
    parameter DOM_CYC     = `CTFS_DOM_MIN_CYC,
    parameter EDGES       = `CTFS_FAULT_EDGES
) (
    input  wire                   clk_sys_i,             // 100 MHz clock
    input  wire                   rst_i,                 // async reset, high
    input  wire                   txd_i,                 // transmit, low=dominant
    input  wire                   bus_rx_i,              // bus level, low=dominant
    input  wire [`CTFS_BF_W-1:0]  bus_fault_cond_i,      // analog fault detectors
    input  wire                   thermal_warn_i,        // over warning threshold
    input  wire                   thermal_over_i,        // over shutdown threshold
    input  wire                   battery_uv_i,          // below falling threshold
    input  wire                   regulator_uv_i,        // regulator undervoltage
    input  wire                   regulator_ov_i,        // regulator overvoltage
    input  wire                   failsafe_en_i,         // fail-safe mode enabled
    input  wire                   mode_wr_i,             // mode write strobe
    input  wire [1:0]             mode_wdata_i,          // requested mode
    input  wire                   flag_wr_i,             // flag clear strobe
    input  wire [`CTFS_BF_W-1:0]  bus_fault_clr_i,       // write-one-to-clear mask
    input  wire [3:0]             evt_clr_i,             // clear warn,tsd,ov,uv
    output reg  [`CTFS_BF_W-1:0]  bus_fault_o,           // bus fault flags
    output reg                    thermal_warn_flag_o,   // warning flag
    output reg                    thermal_shutdown_flag_o, // shutdown flag
    output reg                    regulator_ov_flag_o,   // overvoltage flag
    output reg                    battery_uv_flag_o,     // battery undervoltage flag
    output reg                    irq_o,                 // interrupt, high active
    output reg                    can_drv_en_o,          // driver enable
    output reg                    can_xcvr_en_o,         // transceiver enable
    output reg                    bus_tx_o,              // to driver, high=recessive
    output reg                    rxd_o,                 // to host, high=recessive
    output reg                    host_if_en_o,          // host interface enabled
    output reg                    supply_inhibit_output_o, // external supply enable
    output reg                    sleep_wake_error_timer_start_o, // pulse
    output reg                    dominant_timeout_o,    // timeout active
    output reg  [2:0]             state_o                // protection state
);
    localparam ST_STANDBY  = `CTFS_ST_STANDBY;
    localparam ST_NORMAL   = `CTFS_ST_NORMAL;
    localparam ST_SLEEP    = `CTFS_ST_SLEEP;
    localparam ST_TSD      = `CTFS_ST_TSD;
    localparam ST_FAILSAFE = `CTFS_ST_FAILSAFE;
    localparam ST_BUV      = `CTFS_ST_BUV;

    // shared saturating step for the long timers
    function [31:0] ctfs_inc;
        input [31:0] v;
        begin
            ctfs_inc = (v == 32'hFFFFFFFF) ? v : v + 32'h1;
        end
    endfunction

    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg  [31:0] tsd_cnt_r;
    reg  [31:0] dto_cnt_r;
    reg  [31:0] slp_cnt_r;
    reg         slp_run_r;
    reg         txd_d_r;
    reg         warn_d_r;
    reg         tsd_d_r;
    reg         ov_d_r;
    reg         bus_d_r;
    reg  [15:0] dom_cnt_r;
    reg  [2:0]  edge_cnt_r [0:`CTFS_BF_W-1];
    reg         buv_d_r;
    wire        buv_hit;
    wire        ruv_hit;
    integer     i;

    ctfs_filter #(.CNT(BUV_CYC)) u_buv (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .level_i   (battery_uv_i),
        .hit_o     (buv_hit)
    );

    ctfs_filter #(.CNT(RUV_CYC)) u_ruv (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .level_i   (regulator_uv_i),
        .hit_o     (ruv_hit)
    );

    wire tsd_rise   = thermal_over_i & ~tsd_d_r;
    wire recheck_ok = (tsd_cnt_r >= RECHECK_CYC - 1) & ~thermal_over_i;
    wire slp_expire = slp_run_r & (slp_cnt_r >= UVSLP_CYC - 1) & ruv_hit;
    wire protect    = (state_r == ST_TSD) | (state_r == ST_FAILSAFE) |
                      (state_r == ST_BUV) | (state_r == ST_SLEEP) | ruv_hit;

    // protection state machine
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_STANDBY, ST_NORMAL, ST_SLEEP: begin
                if (mode_wr_i && mode_wdata_i == `CTFS_MODE_NORMAL)
                    state_nxt = ST_NORMAL;
                else if (mode_wr_i && mode_wdata_i == `CTFS_MODE_STANDBY)
                    state_nxt = ST_STANDBY;
                else if (mode_wr_i && mode_wdata_i == `CTFS_MODE_SLEEP)
                    state_nxt = ST_SLEEP;
            end
            ST_TSD: begin
                if (mode_wr_i && mode_wdata_i == `CTFS_MODE_SLEEP)
                    state_nxt = ST_SLEEP;
                else if (recheck_ok)
                    state_nxt = ST_STANDBY;
            end
            ST_FAILSAFE: begin
                if (recheck_ok && !regulator_ov_i)
                    state_nxt = ST_STANDBY;
            end
            ST_BUV: begin
                if (!battery_uv_i)
                    state_nxt = ST_STANDBY;
            end
            default: state_nxt = ST_STANDBY;
        endcase
        // faults take priority over any mode write
        if (slp_expire)
            state_nxt = ST_SLEEP;
        if (tsd_rise)
            state_nxt = failsafe_en_i ? ST_FAILSAFE : ST_TSD;
        if (regulator_ov_i && !ov_d_r)
            state_nxt = ST_FAILSAFE;
        if (buv_hit)
            state_nxt = ST_BUV;
    end

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_r   <= ST_STANDBY;
            tsd_cnt_r <= 32'h0;
            dto_cnt_r <= 32'h0;
            slp_cnt_r <= 32'h0;
            slp_run_r <= 1'b0;
            txd_d_r   <= 1'b1;
            warn_d_r  <= 1'b0;
            tsd_d_r   <= 1'b0;
            ov_d_r    <= 1'b0;
            bus_d_r   <= 1'b1;
            dom_cnt_r <= 16'h0;
            buv_d_r   <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            txd_d_r  <= txd_i;
            warn_d_r <= thermal_warn_i;
            tsd_d_r  <= thermal_over_i;
            ov_d_r   <= regulator_ov_i;
            bus_d_r  <= bus_rx_i;
            buv_d_r  <= buv_hit;
            // timer restarts at onset and after every recheck
            if (tsd_rise || recheck_ok || state_r != state_nxt)
                tsd_cnt_r <= 32'h0;
            else if (tsd_cnt_r >= RECHECK_CYC - 1)
                tsd_cnt_r <= 32'h0;
            else
                tsd_cnt_r <= ctfs_inc(tsd_cnt_r);
            // dominant timeout counter starts on a falling edge
            if (txd_i)
                dto_cnt_r <= 32'h0;
            else if (txd_d_r)
                dto_cnt_r <= 32'h1;
            else
                dto_cnt_r <= ctfs_inc(dto_cnt_r);
            if (!ruv_hit) begin
                slp_run_r <= 1'b0;
                slp_cnt_r <= 32'h0;
            end else begin
                slp_run_r <= 1'b1;
                slp_cnt_r <= slp_run_r ? ctfs_inc(slp_cnt_r) : 32'h0;
            end
            // dominant bit length measured on the bus
            if (bus_rx_i)
                dom_cnt_r <= 16'h0;
            else if (dom_cnt_r != 16'hFFFF)
                dom_cnt_r <= dom_cnt_r + 16'h1;
        end
    end

    // a qualifying edge is dominant-to-recessive after a long enough dominant bit
    // the bit must last strictly longer than the minimum; exactly the limit is too short
    // limitation: length is counted in whole cycles of the sampled bus level
    wire long_edge = bus_rx_i & ~bus_d_r & (dom_cnt_r > DOM_CYC);

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            for (i = 0; i < `CTFS_BF_W; i = i + 1)
                edge_cnt_r[i] <= 3'h0;
            bus_fault_o <= {`CTFS_BF_W{1'b0}};
        end else begin
            for (i = 0; i < `CTFS_BF_W; i = i + 1) begin
                if (!bus_fault_cond_i[i])
                    edge_cnt_r[i] <= 3'h0;
                else if (long_edge && edge_cnt_r[i] < EDGES)
                    edge_cnt_r[i] <= edge_cnt_r[i] + 3'h1;
                // set wins over a simultaneous write-one clear
                if (bus_fault_cond_i[i] && long_edge && edge_cnt_r[i] == EDGES - 1)
                    bus_fault_o[i] <= 1'b1;
                else if (flag_wr_i && bus_fault_clr_i[i])
                    bus_fault_o[i] <= 1'b0;
            end
        end
    end

    // event flags and derived outputs
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            thermal_warn_flag_o            <= 1'b0;
            thermal_shutdown_flag_o        <= 1'b0;
            regulator_ov_flag_o            <= 1'b0;
            battery_uv_flag_o              <= 1'b0;
            irq_o                          <= 1'b0;
            can_drv_en_o                   <= 1'b0;
            can_xcvr_en_o                  <= 1'b0;
            bus_tx_o                       <= 1'b1;
            rxd_o                          <= 1'b1;
            host_if_en_o                   <= 1'b1;
            supply_inhibit_output_o        <= 1'b1;
            sleep_wake_error_timer_start_o <= 1'b0;
            dominant_timeout_o             <= 1'b0;
            state_o                        <= ST_STANDBY;
        end else begin
            if (thermal_warn_i && !warn_d_r)
                thermal_warn_flag_o <= 1'b1;
            else if (flag_wr_i && evt_clr_i[0])
                thermal_warn_flag_o <= 1'b0;
            if (tsd_rise)
                thermal_shutdown_flag_o <= 1'b1;
            else if (flag_wr_i && evt_clr_i[1])
                thermal_shutdown_flag_o <= 1'b0;
            if (regulator_ov_i && !ov_d_r)
                regulator_ov_flag_o <= 1'b1;
            else if (flag_wr_i && evt_clr_i[2])
                regulator_ov_flag_o <= 1'b0;
            if (buv_hit && !buv_d_r)
                battery_uv_flag_o <= 1'b1;
            else if (flag_wr_i && evt_clr_i[3])
                battery_uv_flag_o <= 1'b0;
            irq_o <= (|bus_fault_o) | thermal_warn_flag_o | thermal_shutdown_flag_o |
                     regulator_ov_flag_o | battery_uv_flag_o;
            // only normal mode drives; protection states hold it off
            can_xcvr_en_o <= (state_nxt == ST_NORMAL) & ~ruv_hit;
            can_drv_en_o  <= (state_nxt == ST_NORMAL) & ~ruv_hit &
                             ~(~txd_i & (dto_cnt_r >= DTO_CYC - 1)) &
                             ~(dominant_timeout_o & ~txd_i);
            if (txd_i)
                dominant_timeout_o <= 1'b0;
            else if (dto_cnt_r >= DTO_CYC - 1)
                dominant_timeout_o <= 1'b1;
            // recessive bias when the driver is off
            bus_tx_o <= (state_nxt == ST_NORMAL) & ~protect & ~dominant_timeout_o &
                        ~(~txd_i & (dto_cnt_r >= DTO_CYC - 1)) ? txd_i : 1'b1;
            // receiver stays live except under battery undervoltage
            rxd_o <= (state_nxt == ST_BUV) ? 1'b1 : bus_rx_i;
            host_if_en_o <= (state_nxt != ST_BUV);
            // core keeps running in thermal shutdown so register port stays up
            if (buv_hit)
                supply_inhibit_output_o <= 1'b0;
            else if (state_nxt != ST_SLEEP)
                supply_inhibit_output_o <= 1'b1;
            else
                supply_inhibit_output_o <= 1'b0;
            sleep_wake_error_timer_start_o <= (state_r == ST_BUV) &&
                                              (state_nxt == ST_STANDBY);
            state_o <= state_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> dv/ctfs_sup_assertions.sv
// concurrent checks on the fault supervisor ports
`timescale 1ns/10ps
`default_nettype none
`include "ctfs_map.vh"
module ctfs_sup_chk #(
    parameter int DTO_CYC = 30,
    parameter int BUV_CYC = 10
) (
    input wire logic                  clk_sys_i,         // clock
    input wire logic                  rst_i,             // reset
    input wire logic                  txd_i,             // transmit
    input wire logic                  battery_uv_i,      // battery low
    input wire logic                  thermal_over_i,    // overtemperature
    input wire logic                  mode_wr_i,         // mode strobe
    input wire logic [1:0]            mode_wdata_i,      // mode value
    input wire logic                  flag_wr_i,         // clear strobe
    input wire logic [`CTFS_BF_W-1:0] bus_fault_o,       // bus flags
    input wire logic                  thermal_warn_flag_o, // warn flag
    input wire logic                  thermal_shutdown_flag_o, // tsd flag
    input wire logic                  regulator_ov_flag_o, // ov flag
    input wire logic                  battery_uv_flag_o, // uv flag
    input wire logic                  irq_o,             // interrupt
    input wire logic                  can_drv_en_o,      // driver on
    input wire logic                  can_xcvr_en_o,     // transceiver on
    input wire logic                  bus_tx_o,          // bus drive
    input wire logic                  rxd_o,             // host receive
    input wire logic                  host_if_en_o,      // host port on
    input wire logic                  supply_inhibit_output_o, // inhibit
    input wire logic                  dominant_timeout_o, // timeout
    input wire logic [2:0]            state_o            // state
);
    logic [31:0] low_r;
    logic [31:0] buv_r;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // run lengths of the two filtered conditions, saturation not needed at sim counts
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            low_r <= 32'h0;
            buv_r <= 32'h0;
        end else begin
            low_r <= txd_i ? 32'h0 : low_r + 32'h1;
            buv_r <= battery_uv_i ? buv_r + 32'h1 : 32'h0;
        end
    end
    sequence tsd_entry_s; state_o == `CTFS_ST_TSD && thermal_over_i; endsequence
    sequence tsd_wr_s; tsd_entry_s ##0 mode_wr_i && mode_wdata_i != `CTFS_MODE_SLEEP; endsequence
    tsd_block_a: assert property (state_o == `CTFS_ST_TSD |-> !can_xcvr_en_o && bus_tx_o)
        else $error("transmit path open in thermal shutdown");
    tsd_ignore_a: assert property (tsd_wr_s |=> state_o == `CTFS_ST_TSD)
        else $error("mode write left thermal shutdown");
    fs_off_a: assert property (state_o == `CTFS_ST_FAILSAFE |-> !can_xcvr_en_o)
        else $error("transceiver on in fail-safe");
    dto_len_a: assert property ($rose(dominant_timeout_o) |-> low_r >= DTO_CYC - 1 && low_r <= DTO_CYC + 2)
        else $error("dominant timeout at wrong length");
    dto_hold_a: assert property (dominant_timeout_o |-> !can_drv_en_o && bus_tx_o)
        else $error("driver active during dominant timeout");
    dto_clear_a: assert property (dominant_timeout_o && txd_i |=> !dominant_timeout_o)
        else $error("timeout kept after recessive transmit");
    w1c_only_a: assert property (!$past(flag_wr_i) |-> ($past(bus_fault_o) & ~bus_fault_o) == 6'h0)
        else $error("bus fault flag dropped without clear");
    irq_or_a: assert property (irq_o == $past(|{bus_fault_o, thermal_warn_flag_o, thermal_shutdown_flag_o, regulator_ov_flag_o, battery_uv_flag_o}))
        else $error("interrupt not the or of flags");
    buv_filt_a: assert property ($rose(battery_uv_flag_o) |-> buv_r >= BUV_CYC - 1)
        else $error("battery undervoltage not filtered");
    buv_host_a: assert property (state_o == `CTFS_ST_BUV |-> !host_if_en_o && rxd_o && !supply_inhibit_output_o)
        else $error("host signalling in battery undervoltage");
endmodule
bind ctfs_supervisor ctfs_sup_chk #(.DTO_CYC(DTO_CYC), .BUV_CYC(BUV_CYC)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .txd_i(txd_i), .battery_uv_i(battery_uv_i),
    .thermal_over_i(thermal_over_i), .mode_wr_i(mode_wr_i), .mode_wdata_i(mode_wdata_i),
    .flag_wr_i(flag_wr_i), .bus_fault_o(bus_fault_o), .thermal_warn_flag_o(thermal_warn_flag_o),
    .thermal_shutdown_flag_o(thermal_shutdown_flag_o), .regulator_ov_flag_o(regulator_ov_flag_o),
    .battery_uv_flag_o(battery_uv_flag_o), .irq_o(irq_o), .can_drv_en_o(can_drv_en_o),
    .can_xcvr_en_o(can_xcvr_en_o), .bus_tx_o(bus_tx_o), .rxd_o(rxd_o), .host_if_en_o(host_if_en_o),
    .supply_inhibit_output_o(supply_inhibit_output_o), .dominant_timeout_o(dominant_timeout_o),
    .state_o(state_o));
`default_nettype wire

// >>> dv/ctfs_bus_model.sv
// wired-and can bus with one remote node, termination pulls it recessive
`timescale 1ns/10ps
`default_nettype none
module ctfs_bus_model (
    input  wire logic drv_en_i,  // local driver enabled
    input  wire logic xcvr_en_i, // local transceiver enabled
    input  wire logic tx_i,      // local drive, high recessive
    input  wire logic peer_n_i,  // remote node, low dominant
    output wire logic bus_o      // resulting bus level
);
    // a disabled local node leaves the bus to the termination
    assign bus_o = (drv_en_i && xcvr_en_i ? tx_i : 1'b1) & peer_n_i;
endmodule
`default_nettype wire

// >>> dv/ctfs_supervisor_bench.sv
// self-checking bench of the fault supervisor
`timescale 1ns/10ps
`default_nettype none
`include "ctfs_map.vh"
module ctfs_supervisor_bench;
    localparam integer RCK = 40, DOMINANT_TIMEOUT = 30, BUV = 10, RUV = 10, USL = 40, DOM = 150;
    logic clk_sys_i = 0, rst_i = 1, txd_i = 1, peer_n = 1, bus_rx;
    logic thermal_warn_i = 0, thermal_over_i = 0, battery_uv_i = 0;
    logic regulator_uv_i = 0, regulator_ov_i = 0, failsafe_en_i = 0;
    logic mode_wr_i = 0, flag_wr_i = 0;
    logic [1:0] mode_wdata_i = 2'h0;
    logic [3:0] evt_clr_i = 4'h0;
    logic [5:0] cond = 6'h0, clr = 6'h0, bf;
    logic twf, tsf, ovf, buf_f, irq, drv, xcvr, btx, rxd, hif, supply_inhibit_output, sleep_wake_error_timer, dominant_timeout;
    logic [2:0] st;
    integer err_total = 0, samples_checked = 0, i;
    ctfs_supervisor #(.RECHECK_CYC(RCK), .DTO_CYC(DOMINANT_TIMEOUT), .BUV_CYC(BUV), .RUV_CYC(RUV),
        .UVSLP_CYC(USL), .DOM_CYC(DOM), .EDGES(4)) dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .txd_i(txd_i), .bus_rx_i(bus_rx),
        .bus_fault_cond_i(cond), .thermal_warn_i(thermal_warn_i), .thermal_over_i(thermal_over_i),
        .battery_uv_i(battery_uv_i), .regulator_uv_i(regulator_uv_i), .regulator_ov_i(regulator_ov_i),
        .failsafe_en_i(failsafe_en_i), .mode_wr_i(mode_wr_i), .mode_wdata_i(mode_wdata_i),
        .flag_wr_i(flag_wr_i), .bus_fault_clr_i(clr), .evt_clr_i(evt_clr_i), .bus_fault_o(bf),
        .thermal_warn_flag_o(twf), .thermal_shutdown_flag_o(tsf), .regulator_ov_flag_o(ovf),
        .battery_uv_flag_o(buf_f), .irq_o(irq), .can_drv_en_o(drv), .can_xcvr_en_o(xcvr),
        .bus_tx_o(btx), .rxd_o(rxd), .host_if_en_o(hif), .supply_inhibit_output_o(supply_inhibit_output),
        .sleep_wake_error_timer_start_o(sleep_wake_error_timer), .dominant_timeout_o(dominant_timeout), .state_o(st));
    ctfs_bus_model u_bus (.drv_en_i(drv), .xcvr_en_i(xcvr), .tx_i(btx), .peer_n_i(peer_n),
        .bus_o(bus_rx));
    initial forever #5 clk_sys_i = ~clk_sys_i;
    task test_done;
        if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task cyc(input integer n); repeat (n) @(posedge clk_sys_i); #1; endtask
    task chk(input logic ok, input string m);
        samples_checked = samples_checked + 1;
        if (ok !== 1'b1) begin
            err_total = err_total + 1;
            $display("Error at %0t: %s", $time, m);
        end
    endtask
    task wait_st(input [2:0] s, input integer n);
        for (i = 0; i < n && st !== s; i = i + 1) cyc(1);
        if (st !== s) begin chk(1'b0, "state wait timed out"); test_done; end
    endtask
    task do_reset; rst_i = 1; cyc(16); rst_i = 0; cyc(1); endtask
    task mode(input [1:0] m); mode_wdata_i = m; mode_wr_i = 1; cyc(1); mode_wr_i = 0; cyc(2); endtask
    task pulse(input integer n); peer_n = 0; cyc(n); peer_n = 1; cyc(20); endtask
    task t_reset;
        chk({bf, twf, tsf, ovf, buf_f, irq, st} === 14'h0, "reset flags");
        chk({btx, rxd, hif, supply_inhibit_output} === 4'hF, "reset outputs");
    endtask
    task t_dto;
        mode(`CTFS_MODE_NORMAL);
        chk(st === `CTFS_ST_NORMAL && drv === 1'b1, "normal mode driver");
        txd_i = 0; cyc(DOMINANT_TIMEOUT - 6); txd_i = 1; cyc(2);
        chk(dominant_timeout === 1'b0 && drv === 1'b1, "short dominant timed out");
        txd_i = 0; cyc(DOMINANT_TIMEOUT + 5);
        chk(dominant_timeout === 1'b1 && drv === 1'b0 && btx === 1'b1, "no dominant timeout");
        peer_n = 0; cyc(3);
        chk(rxd === 1'b0, "receiver idle during timeout");
        peer_n = 1; txd_i = 1; cyc(3);
        chk(dominant_timeout === 1'b0 && drv === 1'b1 && rxd === 1'b1, "timeout not cleared");
        mode(`CTFS_MODE_STANDBY);
        chk(st === `CTFS_ST_STANDBY && xcvr === 1'b0, "standby write refused");
    endtask
    task t_busfault;
        for (integer b = 0; b < 6; b = b + 1) begin
            cond = 6'h1 << b;
            pulse(DOM); pulse(DOM + 10); pulse(DOM + 10); pulse(DOM + 10);
            chk(bf === 6'h0, "fault after three edges");
            pulse(DOM + 10);
            chk(bf === cond && irq === 1'b1, "fault kind flag");
            cond = 6'h0; clr = ~(6'h1 << b); flag_wr_i = 1; cyc(1); flag_wr_i = 0; cyc(1);
            chk(bf === 6'h1 << b, "wrong flag cleared");
            clr = 6'h1 << b; flag_wr_i = 1; cyc(1); flag_wr_i = 0; cyc(2);
            chk(bf === 6'h0, "flag not cleared");
        end
    endtask
    task t_thermal;
        thermal_warn_i = 1; cyc(3);
        chk(twf === 1'b1 && irq === 1'b1, "warning interrupt");
        thermal_over_i = 1; cyc(3);
        chk(st === `CTFS_ST_TSD && xcvr === 1'b0 && btx === 1'b1, "shutdown state");
        chk(tsf === 1'b1 && irq === 1'b1 && hif === 1'b1, "shutdown flag");
        mode(`CTFS_MODE_NORMAL); mode(`CTFS_MODE_STANDBY);
        chk(st === `CTFS_ST_TSD, "mode write obeyed");
        thermal_over_i = 0; wait_st(`CTFS_ST_STANDBY, RCK + 10);
        mode(`CTFS_MODE_NORMAL);
        chk(xcvr === 1'b1, "transceiver not re-enabled");
        thermal_over_i = 1; cyc(RCK + 10); mode(`CTFS_MODE_SLEEP);
        chk(st === `CTFS_ST_SLEEP, "sleep refused");
        failsafe_en_i = 1; do_reset; cyc(2);
        chk(st === `CTFS_ST_FAILSAFE && xcvr === 1'b0, "no fail-safe");
        thermal_over_i = 0; thermal_warn_i = 0; failsafe_en_i = 0;
    endtask
    task t_supply;
        do_reset; battery_uv_i = 1; cyc(BUV - 4); battery_uv_i = 0; cyc(3);
        chk(buf_f === 1'b0 && st === `CTFS_ST_STANDBY, "glitch taken");
        battery_uv_i = 1; wait_st(`CTFS_ST_BUV, BUV + 10); peer_n = 0; cyc(3);
        chk(buf_f === 1'b1 && hif === 1'b0 && supply_inhibit_output === 1'b0 && rxd === 1'b1, "uv host");
        peer_n = 1; battery_uv_i = 0;
        for (i = 0; i < 10 && sleep_wake_error_timer !== 1'b1; i = i + 1) cyc(1);
        chk(sleep_wake_error_timer === 1'b1 && st === `CTFS_ST_STANDBY, "no recovery");
        regulator_uv_i = 1; cyc(RUV + USL - 6);
        chk(st !== `CTFS_ST_SLEEP, "early sleep");
        wait_st(`CTFS_ST_SLEEP, 20); regulator_uv_i = 0;
        do_reset; regulator_ov_i = 1; evt_clr_i = 4'hF; flag_wr_i = 1; cyc(1); flag_wr_i = 0; cyc(2);
        chk(ovf === 1'b1 && st === `CTFS_ST_FAILSAFE && xcvr === 1'b0, "ov");
        regulator_ov_i = 0; flag_wr_i = 1; cyc(1); flag_wr_i = 0; cyc(3);
        chk(ovf === 1'b0 && irq === 1'b0, "ov flag kept");
    endtask
    initial begin
        do_reset;
        t_reset;
        t_dto;
        t_busfault;
        t_thermal;
        t_supply;
        test_done;
    end
endmodule
`default_nettype wire
